// ### inc/timer_core_defs.vh
`ifndef TIMER_CORE_DEFS_VH
`define TIMER_CORE_DEFS_VH

// register word indices on the internal 16-bit bus
`define ADDR_COUNTER_BASE    5'h00
`define ADDR_GENERAL_BASE    5'h05
`define ADDR_BUFFER_BASE     5'h0F
`define ADDR_MASTER_ENABLE   5'h13
`define ADDR_OUTPUT_CONTROL  5'h14

// reset values
`define COUNTER_RESET        16'h0000
`define GENERAL_RESET        16'hFFFF
`define BUFFER_RESET         16'hFFFF
`define MASTER_ENABLE_RESET  8'hFF
`define OUTPUT_CONTROL_RESET 8'hFF
`define READ_ZERO            16'h0000

// counter limits and step
`define COUNT_MAX            16'hFFFF
`define COUNT_MIN            16'h0000
`define COUNT_STEP           16'h0001

// writable bits; all other bits read back as 1
`define MASTER_ENABLE_WMASK  8'h3F
`define OUTPUT_CONTROL_WMASK 8'h13

// output control field positions
`define OCTL_TRIGGER_DISABLE 4
`define OCTL_LEVEL_HI        1
`define OCTL_LEVEL_LO        0

// pin order follows master enable bit order
`define PIN_CH3_A            0
`define PIN_COUNT            6
`define INVERT_MASK_HI       6'h07
`define INVERT_MASK_LO       6'h38

// channel numbers
`define CHANNEL_COUNT        5
`define CH_TRIGGER           1
`define CH_PHASE             2
`define CH_PAIR_FIRST        3

`endif

// ### verilog/timer_channel.v
`timescale 1ns/10ps
`include "timer_core_defs.vh"

module timer_channel #(
  parameter HAS_BUFFER = 0
) (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        standby,
  input  wire        countTick,
  input  wire        countDown,
  input  wire        captureModeA,
  input  wire        captureModeB,
  input  wire        clearOnA,
  input  wire        clearOnB,
  input  wire        bufferEnA,
  input  wire        bufferEnB,
  input  wire        captureEdgeA,
  input  wire        captureEdgeB,
  input  wire [1:0]  byteEn,
  input  wire [15:0] writeData,
  input  wire        writeCounter,
  input  wire        writeGa,
  input  wire        writeGb,
  input  wire        writeBa,
  input  wire        writeBb,
  output reg  [15:0] counter,
  output reg  [15:0] generalA,
  output reg  [15:0] generalB,
  output reg  [15:0] bufferA,
  output reg  [15:0] bufferB,
  output reg         overflowEvent,
  output reg         flagEventA,
  output reg         flagEventB
);

  // byte-lane merge for word and byte writes
  function [15:0] mergeBytes;
    input [15:0] oldValue;
    input [15:0] newValue;
    input [1:0]  lanes;
    begin
      mergeBytes = {lanes[1] ? newValue[15:8] : oldValue[15:8],
                    lanes[0] ? newValue[7:0]  : oldValue[7:0]};
    end
  endfunction

  wire        useBufA = (HAS_BUFFER != 0) & bufferEnA;
  wire        useBufB = (HAS_BUFFER != 0) & bufferEnB;
  wire        matchA;
  wire        matchB;
  wire        captA;
  wire        captB;
  wire        clearNow;
  wire        wrapNow;
  reg  [15:0] next_counter;

  // compare on the count edge, capture on a qualified pin edge
  assign matchA   = ~captureModeA & countTick & (counter == generalA);
  assign matchB   = ~captureModeB & countTick & (counter == generalB);
  assign captA    = captureModeA & captureEdgeA;
  assign captB    = captureModeB & captureEdgeB;
  assign clearNow = (clearOnA & (matchA | captA)) | (clearOnB & (matchB | captB));
  assign wrapNow  = countTick & ~clearNow & ~writeCounter &
                    (countDown ? (counter == `COUNT_MIN) : (counter == `COUNT_MAX));

  // counter: cpu write beats clear, clear beats count
  always @* begin
    next_counter = counter;
    if (writeCounter) begin
      next_counter = mergeBytes(counter, writeData, byteEn);
    end else if (clearNow) begin
      next_counter = `COUNTER_RESET;
    end else if (countTick) begin
      next_counter = countDown ? counter - `COUNT_STEP : counter + `COUNT_STEP;
    end
  end

  // register state, standby acts like reset
  always @(posedge clk_sys) begin
    if (!nrst || standby) begin
      counter       <= `COUNTER_RESET;
      generalA      <= `GENERAL_RESET;
      generalB      <= `GENERAL_RESET;
      bufferA       <= `BUFFER_RESET;
      bufferB       <= `BUFFER_RESET;
      overflowEvent <= 1'b0;
      flagEventA    <= 1'b0;
      flagEventB    <= 1'b0;
    end else begin
      counter       <= next_counter;
      overflowEvent <= wrapNow;
      flagEventA    <= matchA | captA;
      flagEventB    <= matchB | captB;
      if (writeGa) begin
        generalA <= mergeBytes(generalA, writeData, byteEn);
      end else if (captA) begin
        generalA <= counter;
      end else if (matchA && useBufA) begin
        generalA <= bufferA;
      end
      if (writeGb) begin
        generalB <= mergeBytes(generalB, writeData, byteEn);
      end else if (captB) begin
        generalB <= counter;
      end else if (matchB && useBufB) begin
        generalB <= bufferB;
      end
      if (writeBa && (HAS_BUFFER != 0)) begin
        bufferA <= mergeBytes(bufferA, writeData, byteEn);
      end else if (captA && useBufA) begin
        bufferA <= generalA;
      end
      if (writeBb && (HAS_BUFFER != 0)) begin
        bufferB <= mergeBytes(bufferB, writeData, byteEn);
      end else if (captB && useBufB) begin
        bufferB <= generalB;
      end
    end
  end

endmodule // timer_channel

// ### verilog/timer_counter_core.v
// Contract
// - enable bit zero blocks ch3 A output
// - channel-1 capture A clears ch3 A enable
// - enable bit one passes ch3 A output
// - trigger and level bits only in paired modes
// - output control resets to all ones
// - reserved output control bits read one
// - external trigger clears all six enables
// - trigger disabled leaves enables untouched
// - high level select inverts three outputs
// - low level select inverts other three
// - five 16-bit counters advance on tick
// - only channels 2, 3, 4 count down
// - compare or capture may clear counter
// - upward wrap sets overflow flag
// - downward wrap sets overflow flag
// - word and byte access to counters, registers
// - counters reset to zero, also standby
// - io control picks compare or capture
// - compare equality raises A or B flag
// - capture edge stores counter, raises flag
// - pwm modes ignore io control settings
// - general registers reset to compare, ones
// - only channels 3, 4 have buffers
// - buffer transfers on match or capture
`timescale 1ns/10ps
`include "timer_core_defs.vh"

module timer_counter_core (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        standby,
  input  wire [4:0]  busAddr,
  input  wire        busWrite,
  input  wire [1:0]  busByteEn,
  input  wire [15:0] busWdata,
  output reg  [15:0] busRdata,
  input  wire [4:0]  countTick,
  input  wire [4:0]  countDown,
  input  wire [4:0]  pwmMode,
  input  wire        complementaryPwm,
  input  wire        resetSyncPwm,
  input  wire        phaseCounting,
  input  wire [4:0]  ioCaptureA,
  input  wire [4:0]  ioCaptureB,
  input  wire [4:0]  captureRiseA,
  input  wire [4:0]  captureFallA,
  input  wire [4:0]  captureRiseB,
  input  wire [4:0]  captureFallB,
  input  wire [4:0]  clearOnA,
  input  wire [4:0]  clearOnB,
  input  wire [3:0]  bufferEnable,
  input  wire [4:0]  capturePinA,
  input  wire [4:0]  capturePinB,
  input  wire [5:0]  timerOutLevel,
  input  wire [5:0]  timerOutEnable,
  output reg  [5:0]  pinOut,
  output reg  [5:0]  pinOe,
  output wire [4:0]  overflowEvent,
  output wire [4:0]  matchCaptureEventA,
  output wire [4:0]  matchCaptureEventB
);

  // word index decoders, shared by write strobes and read mux
  function [4:0] counterAddr;
    input integer ch;
    begin
      counterAddr = `ADDR_COUNTER_BASE + ch[4:0];
    end
  endfunction

  function [4:0] generalAddr;
    input integer ch;
    input         isB;
    begin
      generalAddr = `ADDR_GENERAL_BASE + {ch[3:0], isB};
    end
  endfunction

  function [4:0] bufferAddr;
    input integer ch;
    input         isB;
    reg   [4:0]   rel;
    integer       relWide;
    begin
      relWide    = ch - `CH_PAIR_FIRST;
      rel        = relWide[4:0];
      bufferAddr = `ADDR_BUFFER_BASE + {rel[3:0], isB};
    end
  endfunction

  // software-visible 8-bit registers
  reg  [7:0]  masterEnable;
  reg  [7:0]  outputControl;

  // capture pin synchronisers and edge history
  reg  [4:0]  syncA1;
  reg  [4:0]  syncA2;
  reg  [4:0]  prevA;
  reg  [4:0]  syncB1;
  reg  [4:0]  syncB2;
  reg  [4:0]  prevB;

  // read path
  reg  [15:0] next_rdata;
  wire [15:0] masterRead;
  wire [15:0] controlRead;

  // per-channel register views
  wire [79:0] counterBus;
  wire [79:0] generalABus;
  wire [79:0] generalBBus;
  wire [79:0] bufferABus;
  wire [79:0] bufferBBus;

  // capture edges and mode qualification
  wire [4:0]  riseA;
  wire [4:0]  fallA;
  wire [4:0]  riseB;
  wire [4:0]  fallB;
  wire [4:0]  edgeA;
  wire [4:0]  edgeB;
  wire [4:0]  pwmEffective;
  wire [4:0]  captureModeA;
  wire [4:0]  captureModeB;
  wire [4:0]  downEffective;
  wire        pairedPwm;

  // output control decode
  wire        triggerArmed;
  wire        triggerEvent;
  wire        externalTrigger;
  wire        levelSelHi;
  wire        levelSelLo;
  wire [5:0]  invertMask;
  wire [5:0]  next_pinOut;
  wire [5:0]  next_pinOe;

  // bus decode
  wire        clearState;
  wire        hitMaster;
  wire        hitControl;
  wire        writeMaster;
  wire        writeControl;
  wire [7:0]  masterWrite;
  wire [7:0]  controlWrite;
  integer     k;

  // capture pins A pass two flip-flops, then edge detection on the second
  always @(posedge clk_sys) begin
    if (!nrst) begin
      syncA1 <= 5'h00;
      syncA2 <= 5'h00;
      prevA  <= 5'h00;
    end else begin
      syncA1 <= capturePinA;
      syncA2 <= syncA1;
      prevA  <= syncA2;
    end
  end

  // capture pins B, same two-stage synchroniser
  always @(posedge clk_sys) begin
    if (!nrst) begin
      syncB1 <= 5'h00;
      syncB2 <= 5'h00;
      prevB  <= 5'h00;
    end else begin
      syncB1 <= capturePinB;
      syncB2 <= syncB1;
      prevB  <= syncB2;
    end
  end

  // selected edges of the synchronised capture inputs
  assign riseA = syncA2 & ~prevA;
  assign fallA = ~syncA2 & prevA;
  assign riseB = syncB2 & ~prevB;
  assign fallB = ~syncB2 & prevB;
  assign edgeA = (captureRiseA & riseA) | (captureFallA & fallA);
  assign edgeB = (captureRiseB & riseB) | (captureFallB & fallB);

  // mode qualification of io control and count direction
  assign pairedPwm     = complementaryPwm | resetSyncPwm;
  assign pwmEffective  = pwmMode | {pairedPwm, pairedPwm, 3'b000};
  assign captureModeA  = ioCaptureA & ~pwmEffective;
  assign captureModeB  = ioCaptureB & ~pwmEffective;
  assign downEffective = countDown & {complementaryPwm, complementaryPwm, phaseCounting, 2'b00};

  // trigger is armed only in paired modes with the disable bit low
  assign triggerArmed    = pairedPwm & ~outputControl[`OCTL_TRIGGER_DISABLE];

  // channel-1 capture A acts as the shutdown trigger
  assign triggerEvent    = captureModeA[`CH_TRIGGER] & edgeA[`CH_TRIGGER];
  assign externalTrigger = triggerArmed & triggerEvent;

  // level selects take effect only in paired modes
  assign levelSelHi = outputControl[`OCTL_LEVEL_HI];
  assign levelSelLo = outputControl[`OCTL_LEVEL_LO];
  assign invertMask = pairedPwm ?
                      (({`PIN_COUNT{~levelSelHi}} & `INVERT_MASK_HI) |
                       ({`PIN_COUNT{~levelSelLo}} & `INVERT_MASK_LO)) :
                      {`PIN_COUNT{1'b0}};

  // bus decode of the two 8-bit registers, reserved bits forced to one
  assign clearState   = ~nrst | standby;
  assign hitMaster    = (busAddr == `ADDR_MASTER_ENABLE);
  assign hitControl   = (busAddr == `ADDR_OUTPUT_CONTROL);
  assign writeMaster  = busWrite & busByteEn[0] & hitMaster;
  assign writeControl = busWrite & busByteEn[0] & hitControl;
  assign masterWrite  = (busWdata[7:0] & `MASTER_ENABLE_WMASK) | ~`MASTER_ENABLE_WMASK;
  assign controlWrite = (busWdata[7:0] & `OUTPUT_CONTROL_WMASK) | ~`OUTPUT_CONTROL_WMASK;
  assign masterRead   = {8'h00, masterEnable};
  assign controlRead  = {8'h00, outputControl};

  // five channels, buffers only on the paired ones
  genvar c;
  generate
    for (c = 0; c < `CHANNEL_COUNT; c = c + 1) begin : chan
      localparam HAS_BUF = (c >= `CH_PAIR_FIRST) ? 1 : 0;
      wire bufEnA;
      wire bufEnB;
      wire strobeCnt;
      wire strobeGa;
      wire strobeGb;
      wire strobeBa;
      wire strobeBb;
      // write strobes of the registers every channel has
      assign strobeCnt = busWrite && (busAddr == counterAddr(c));
      assign strobeGa  = busWrite && (busAddr == generalAddr(c, 1'b0));
      assign strobeGb  = busWrite && (busAddr == generalAddr(c, 1'b1));
      if (HAS_BUF != 0) begin : buf_sel
        assign bufEnA   = bufferEnable[(c - `CH_PAIR_FIRST) * 2];
        assign bufEnB   = bufferEnable[(c - `CH_PAIR_FIRST) * 2 + 1];
        assign strobeBa = busWrite && (busAddr == bufferAddr(c, 1'b0));
        assign strobeBb = busWrite && (busAddr == bufferAddr(c, 1'b1));
      end else begin : no_buf
        assign bufEnA   = 1'b0;
        assign bufEnB   = 1'b0;
        assign strobeBa = 1'b0;
        assign strobeBb = 1'b0;
      end
      timer_channel #(
        .HAS_BUFFER (HAS_BUF)
      ) u_channel (
        .clk_sys       (clk_sys),
        .nrst          (nrst),
        .standby       (standby),
        .countTick     (countTick[c]),
        .countDown     (downEffective[c]),
        .captureModeA  (captureModeA[c]),
        .captureModeB  (captureModeB[c]),
        .clearOnA      (clearOnA[c]),
        .clearOnB      (clearOnB[c]),
        .bufferEnA     (bufEnA),
        .bufferEnB     (bufEnB),
        .captureEdgeA  (edgeA[c]),
        .captureEdgeB  (edgeB[c]),
        .byteEn        (busByteEn),
        .writeData     (busWdata),
        .writeCounter  (strobeCnt),
        .writeGa       (strobeGa),
        .writeGb       (strobeGb),
        .writeBa       (strobeBa),
        .writeBb       (strobeBb),
        .counter       (counterBus[c*16 +: 16]),
        .generalA      (generalABus[c*16 +: 16]),
        .generalB      (generalBBus[c*16 +: 16]),
        .bufferA       (bufferABus[c*16 +: 16]),
        .bufferB       (bufferBBus[c*16 +: 16]),
        .overflowEvent (overflowEvent[c]),
        .flagEventA    (matchCaptureEventA[c]),
        .flagEventB    (matchCaptureEventB[c])
      );
    end
  endgenerate

  // output control and master enable registers
  always @(posedge clk_sys) begin
    if (clearState) begin
      outputControl <= `OUTPUT_CONTROL_RESET;
      masterEnable  <= `MASTER_ENABLE_RESET;
    end else begin
      if (writeControl) begin
        outputControl <= controlWrite;
      end
      if (externalTrigger) begin
        masterEnable <= ~`MASTER_ENABLE_WMASK;
      end else if (writeMaster) begin
        masterEnable <= masterWrite;
      end
    end
  end

  // next pin values: master enable gates drive, level select inverts
  assign next_pinOut = (timerOutLevel ^ invertMask) & masterEnable[`PIN_COUNT-1:0];
  assign next_pinOe  = timerOutEnable & masterEnable[`PIN_COUNT-1:0];

  // pins come straight from flip-flops
  always @(posedge clk_sys) begin
    if (clearState) begin
      pinOut <= {`PIN_COUNT{1'b0}};
      pinOe  <= {`PIN_COUNT{1'b0}};
    end else begin
      pinOut <= next_pinOut;
      pinOe  <= next_pinOe;
    end
  end

  // read mux, unmapped words read zero
  always @* begin
    next_rdata = `READ_ZERO;
    for (k = 0; k < `CHANNEL_COUNT; k = k + 1) begin
      if (busAddr == counterAddr(k)) begin
        next_rdata = counterBus[k*16 +: 16];
      end
      if (busAddr == generalAddr(k, 1'b0)) begin
        next_rdata = generalABus[k*16 +: 16];
      end
      if (busAddr == generalAddr(k, 1'b1)) begin
        next_rdata = generalBBus[k*16 +: 16];
      end
      if ((k >= `CH_PAIR_FIRST) && (busAddr == bufferAddr(k, 1'b0))) begin
        next_rdata = bufferABus[k*16 +: 16];
      end
      if ((k >= `CH_PAIR_FIRST) && (busAddr == bufferAddr(k, 1'b1))) begin
        next_rdata = bufferBBus[k*16 +: 16];
      end
    end
    if (hitMaster) begin
      next_rdata = masterRead;
    end
    if (hitControl) begin
      next_rdata = controlRead;
    end
  end

  // registered read data
  always @(posedge clk_sys) begin
    if (!nrst) begin
      busRdata <= `READ_ZERO;
    end else begin
      busRdata <= next_rdata;
    end
  end

endmodule // timer_counter_core

// ### verif/timer_counter_core_props.sv
`timescale 1ns/10ps
module timer_counter_core_props (
  input logic        clk_sys,
  input logic        nrst,
  input logic        standby,
  input logic [4:0]  busAddr,
  input logic        busWrite,
  input logic [1:0]  busByteEn,
  input logic [15:0] busWdata,
  input logic [15:0] busRdata,
  input logic [4:0]  countTick,
  input logic [4:0]  ioCaptureA,
  input logic        complementaryPwm,
  input logic        resetSyncPwm,
  input logic [5:0]  timerOutLevel,
  input logic [5:0]  timerOutEnable,
  input logic [5:0]  pinOut,
  input logic [5:0]  pinOe,
  input logic [4:0]  overflowEvent,
  input logic [4:0]  matchCaptureEventA
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // word write to a counter or general register, then a read of the same word
  sequence s_wr;
    busWrite && busByteEn == 2'b11 && busAddr < 5'h0F && !standby;
  endsequence
  sequence s_rd;
    busAddr == $past(busAddr) && !busWrite;
  endsequence
  property p_wr_rd;
    s_wr ##1 s_rd |=> busRdata == $past(busWdata, 2);
  endproperty
  property p_rst_out;
    $rose(nrst) |-> busRdata == 16'h0000 && pinOe == 6'h00 && pinOut == 6'h00;
  endproperty
  property p_standby;
    standby |=> pinOe == 6'h00 && pinOut == 6'h00 && overflowEvent == 5'h00;
  endproperty
  property p_oe_gate;
    $past(nrst) |-> (pinOe & ~$past(timerOutEnable)) == 6'h00;
  endproperty
  property p_plain_level;
    $past(nrst) && !$past(complementaryPwm || resetSyncPwm) |-> (pinOut & ~$past(timerOutLevel)) == 6'h00;
  endproperty
  property p_ovf_tick;
    $past(nrst) |-> (overflowEvent & ~$past(countTick)) == 5'h00;
  endproperty
  property p_cmp_tick;
    $past(nrst) |-> (matchCaptureEventA & ~$past(countTick) & ~$past(ioCaptureA)) == 5'h00;
  endproperty
  property p_ctl_reserved;
    $past(nrst) && $past(busAddr) == 5'h14 |-> busRdata[15:8] == 8'h00 && busRdata[7:5] == 3'b111 && busRdata[3:2] == 2'b11;
  endproperty
  property p_me_reserved;
    $past(nrst) && $past(busAddr) == 5'h13 |-> busRdata[15:6] == 10'h003;
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("word not read back");
  a_rst_out: assert property (p_rst_out) else $error("outputs not clear after reset");
  a_standby: assert property (p_standby) else $error("outputs not clear in standby");
  a_oe_gate: assert property (p_oe_gate) else $error("pin driven without request");
  a_plain_level: assert property (p_plain_level) else $error("level changed outside paired mode");
  a_ovf_tick: assert property (p_ovf_tick) else $error("overflow without tick");
  a_cmp_tick: assert property (p_cmp_tick) else $error("compare flag without tick");
  a_ctl_reserved: assert property (p_ctl_reserved) else $error("control reserved bits wrong");
  a_me_reserved: assert property (p_me_reserved) else $error("enable reserved bits wrong");
endmodule // timer_counter_core_props

bind timer_counter_core timer_counter_core_props u_props (.clk_sys, .nrst, .standby, .busAddr, .busWrite,
  .busByteEn, .busWdata, .busRdata, .countTick, .ioCaptureA, .complementaryPwm, .resetSyncPwm,
  .timerOutLevel, .timerOutEnable, .pinOut, .pinOe, .overflowEvent, .matchCaptureEventA);

// ### verif/tb_timer_counter_core.sv
`timescale 1ns/10ps
module tb_timer_counter_core;
  logic        clk_sys, nrst, standby, busWrite, complementaryPwm, resetSyncPwm, phaseCounting;
  logic [4:0]  busAddr, countTick, countDown, pwmMode, ioCaptureA, ioCaptureB, captureRiseA, captureFallA;
  logic [4:0]  captureRiseB, captureFallB, clearOnA, clearOnB, capturePinA, capturePinB;
  logic [4:0]  overflowEvent, matchCaptureEventA, matchCaptureEventB, ovSeen, mSeen;
  logic [3:0]  bufferEnable;
  logic [1:0]  busByteEn;
  logic [15:0] busWdata, busRdata, rv;
  logic [5:0]  timerOutLevel, timerOutEnable, pinOut, pinOe;
  logic [7:0]  ctl;
  logic [31:0] seed = 32'h9e41_2b76;
  int          failures = 0;
  int          comparisons = 0;

  timer_counter_core dut (.clk_sys, .nrst, .standby, .busAddr, .busWrite, .busByteEn, .busWdata, .busRdata,
    .countTick, .countDown, .pwmMode, .complementaryPwm, .resetSyncPwm, .phaseCounting, .ioCaptureA,
    .ioCaptureB, .captureRiseA, .captureFallA, .captureRiseB, .captureFallB, .clearOnA, .clearOnB,
    .bufferEnable, .capturePinA, .capturePinB, .timerOutLevel, .timerOutEnable, .pinOut, .pinOe,
    .overflowEvent, .matchCaptureEventA, .matchCaptureEventB);

  // xorshift source of repeatable values
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // value of each word after reset or standby
  function automatic logic [15:0] rstVal(input logic [4:0] a);
    if (a < 5'h05) return 16'h0000;
    if (a < 5'h13) return 16'hFFFF;
    if (a < 5'h15) return 16'h00FF;
    return 16'h0000;
  endfunction
  // pin level: inversion only in the two paired modes
  function automatic logic [5:0] pinExp(input logic [5:0] lvl, me, input logic [7:0] c, input logic pr);
    logic [5:0] inv;
    inv = pr ? ((c[1] ? 6'h00 : 6'h07) | (c[0] ? 6'h00 : 6'h38)) : 6'h00;
    return (lvl ^ inv) & me;
  endfunction

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle write strobe, launched and dropped at falling edges
  task automatic wr(input logic [4:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge clk_sys);
    busAddr = a;
    busByteEn = be;
    busWdata = d;
    busWrite = 1'b1;
    @(negedge clk_sys);
    busWrite = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input string nm);
    @(negedge clk_sys);
    busAddr = a;
    @(negedge clk_sys);
    chk(nm, e, busRdata);
  endtask
  task automatic allReset();
    for (int a = 0; a < 22; a++) rd(a[4:0], rstVal(a[4:0]), "reset value");
  endtask
  // one tick, events gathered over the two following cycles
  task automatic tick(input logic [4:0] m);
    @(negedge clk_sys);
    countTick = m;
    @(negedge clk_sys);
    countTick = 5'h00;
    ovSeen = overflowEvent;
    mSeen = matchCaptureEventA;
    @(negedge clk_sys);
    ovSeen |= overflowEvent;
    mSeen |= matchCaptureEventA;
  endtask
  // toggle both capture pins of a channel and wait for the A flag
  task automatic capt(input int ch);
    int n;
    logic expB;
    capturePinA[ch] = ~capturePinA[ch];
    capturePinB[ch] = ~capturePinB[ch];
    expB = ioCaptureB[ch] & (capturePinB[ch] ? captureRiseB[ch] : captureFallB[ch]);
    for (n = 0; n < 8 && matchCaptureEventA[ch] !== 1'b1; n++) @(negedge clk_sys);
    if (n == 8) begin
      failures++;
      $display("unexpected capture flag expected 1 seen 0");
      results();
    end
    chk("capture flag b", 16'(expB), 16'(matchCaptureEventB[ch]));
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    {nrst, standby, busWrite, complementaryPwm, resetSyncPwm, phaseCounting} = '0;
    {busAddr, countTick, countDown, pwmMode, captureFallB, clearOnB, capturePinA, capturePinB} = '0;
    ioCaptureA = 5'h03;
    captureRiseA = 5'h03;
    captureFallA = 5'h02;
    clearOnA = 5'h04;
    ioCaptureB = 5'h01;
    captureRiseB = 5'h01;
    bufferEnable = 4'h1;
    busByteEn = 2'h3;
    busWdata = 16'h0000;
    timerOutLevel = 6'h00;
    timerOutEnable = 6'h3F;
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    allReset();
    $display("test reset done");
    // random words, then a high-byte write that keeps the low byte
    for (int a = 0; a < 15; a++) begin
      rv = rnd();
      wr(a[4:0], 2'h3, rv);
      rd(a[4:0], rv, "word");
      wr(a[4:0], 2'h2, 16'hA5A5);
      rd(a[4:0], {8'hA5, rv[7:0]}, "byte");
    end
    wr(5'h14, 2'h3, 16'h0000);
    rd(5'h14, 16'h00EC, "control reserved");
    wr(5'h13, 2'h3, 16'h0000);
    rd(5'h13, 16'h00C0, "enable reserved");
    wr(5'h15, 2'h3, rnd());
    @(negedge clk_sys);
    standby = 1'b1;
    @(negedge clk_sys);
    standby = 1'b0;
    allReset();
    $display("test access and standby done");
    // ch0 wraps up, ch2 wraps down; down request on ch0 ignored
    wr(5'h00, 2'h3, 16'hFFFE);
    wr(5'h02, 2'h3, 16'h0001);
    phaseCounting = 1'b1;
    countDown = 5'h05;
    tick(5'h05);
    tick(5'h05);
    chk("overflow", 16'h0005, 16'(ovSeen));
    rd(5'h00, 16'h0000, "up counter");
    rd(5'h02, 16'hFFFF, "down counter");
    $display("test counting done");
    // compare match on ch2 A clears the counter
    phaseCounting = 1'b0;
    wr(5'h09, 2'h3, 16'h0010);
    wr(5'h02, 2'h3, 16'h0010);
    tick(5'h04);
    chk("match flag", 16'h0004, 16'(mSeen));
    rd(5'h02, 16'h0000, "cleared counter");
    // buffered compare on ch3 A
    wr(5'h0F, 2'h3, 16'h0055);
    wr(5'h0B, 2'h3, 16'h0005);
    wr(5'h03, 2'h3, 16'h0005);
    tick(5'h08);
    rd(5'h0B, 16'h0055, "buffered compare");
    $display("test compare done");
    // capture on ch0 A and B stores the counter
    wr(5'h00, 2'h3, 16'h1234);
    capt(0);
    rd(5'h05, 16'h1234, "capture a");
    rd(5'h06, 16'h1234, "capture b");
    // write during a running tick keeps the written value
    countTick = 5'h01;
    wr(5'h00, 2'h3, 16'h4321);
    countTick = 5'h00;
    rd(5'h00, 16'h4321, "write priority");
    // pwm mode on ch0 ignores its capture setting
    pwmMode = 5'h01;
    capturePinA[0] = 1'b0;
    repeat (4) @(negedge clk_sys);
    capturePinA[0] = 1'b1;
    repeat (4) @(negedge clk_sys);
    pwmMode = 5'h00;
    rd(5'h05, 16'h1234, "pwm ignores capture");
    $display("test capture done");
    // plain, complementary and reset-synchronized modes
    for (int p = 0; p < 3; p++) begin
      complementaryPwm = (p == 1);
      resetSyncPwm = (p == 2);
      rv = rnd();
      ctl = (p == 1) ? 8'h10 : {6'h04, rv[7:6]};
      timerOutLevel = rv[5:0];
      wr(5'h13, 2'h1, 16'h003E);
      wr(5'h14, 2'h1, {8'h00, ctl});
      repeat (2) @(negedge clk_sys);
      chk("pin level", 16'(pinExp(timerOutLevel, 6'h3E, ctl, p != 0)), 16'(pinOut));
      chk("pin enable", 16'h003E, 16'(pinOe));
      capt(1);
      rd(5'h13, 16'h00FE, "trigger disabled");
      wr(5'h14, 2'h1, 16'h0003);
      capt(1);
      rd(5'h13, (p != 0) ? 16'h00C0 : 16'h00FE, "trigger");
      repeat (2) @(negedge clk_sys);
      chk("pins off", (p != 0) ? 16'h0000 : 16'h003E, 16'(pinOe));
    end
    $display("test pins done");
    results();
  end
endmodule // tb_timer_counter_core
